// >>> verilog/pfm_defs.svh
// Offsets, field positions, reset values and masks of the pin function mux
`ifndef PFM_DEFS_SVH
`define PFM_DEFS_SVH

`define PFM_NUM_REGS 9
`define PFM_OFS_REMAP 8'h00
`define PFM_OFS_PA_LOW 8'h04
`define PFM_OFS_PA_HIGH 8'h08
`define PFM_OFS_PB_LOW 8'h0c
`define PFM_OFS_PB_MID 8'h10
`define PFM_OFS_PB_TOP 8'h14
`define PFM_OFS_PC_LOW 8'h18
`define PFM_OFS_PC_HIGH 8'h1c
`define PFM_OFS_PD 8'h20

`define PFM_RST_SEL 8'h00
`define PFM_MASK_REMAP 8'h7f
`define PFM_MASK_FULL 8'hff
`define PFM_MASK_PB_LOW 8'h7f
`define PFM_MASK_PB_TOP 8'h03
`define PFM_MASK_PC_HIGH 8'h0f

`define PFM_BIT_IRQ1_LOC 6
`define PFM_BIT_RX_LOC 5
`define PFM_BIT_TX_LOC 4
`define PFM_BIT_CMP1_HI 3
`define PFM_BIT_CMP1_LO 2
`define PFM_BIT_SDA_LOC 1
`define PFM_BIT_SCL_LOC 0

`define PFM_NUM_PINS 26
`define PFM_PA0 0
`define PFM_PB0 8
`define PFM_PC0 16
`define PFM_PD0 22

`define PFM_RESP_OKAY 2'b00
`define PFM_RESP_SLVERR 2'b10

`endif

// >>> verilog/pfm_pkg.sv
// Types shared by the pin function mux, its peripheral model and its testbench
package pfm_pkg;

  typedef struct packed {
    logic [5:0] gate_drive;
    logic [2:0] hall_out;
    logic [1:0] timer0_out;
    logic [1:0] timer1_out;
    logic [1:0] timer2_out;
    logic [1:0] timer3_out;
    logic uart_tx;
    logic sda_drive_low;
    logic scl_drive_low;
  } pfm_periph_out_t;

  typedef struct packed {
    logic uart_rx;
    logic sda_in;
    logic scl_in;
    logic external_irq_1;
    logic timer1_clock_input;
    logic timer2_clock_input;
    logic [2:0] hall_in;
    logic capture_timer_input;
    logic noise_filter_input;
  } pfm_periph_in_t;

  typedef enum logic [1:0] {
    PFM_CMP1_PB3 = 2'b00,
    PFM_CMP1_PA6 = 2'b01,
    PFM_CMP1_PA4 = 2'b10,
    PFM_CMP1_RSVD = 2'b11
  } pfm_cmp1_loc_t;

endpackage : pfm_pkg

// >>> verilog/pfm_axil_slave.sv
// AXI4-Lite slave front end for the pin function select registers
`timescale 1ns/10ps
`default_nettype none
`include "pfm_defs.svh"

module pfm_axil_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);

  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // Address and data are held separately so either may arrive first
  assign s_awready = !aw_full_q;
  assign s_wready = !w_full_q;
  assign wr_en = aw_full_q && w_full_q && !bvalid_q;
  assign wr_addr = aw_addr_q;
  assign wr_data = w_data_q;
  assign wr_strb = w_strb_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_arready = !rvalid_q;
  assign rd_addr = s_araddr;
  assign s_rvalid = rvalid_q;
  assign s_rresp = rresp_q;
  assign s_rdata = rdata_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_awvalid && !aw_full_q) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_awaddr;
    end else if (wr_en) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (s_wvalid && !w_full_q) begin
      w_full_q <= 1'b1;
      w_data_q <= s_wdata;
      w_strb_q <= s_wstrb;
    end else if (wr_en) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= `PFM_RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `PFM_RESP_OKAY : `PFM_RESP_SLVERR;
    end else if (s_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rresp_q <= `PFM_RESP_OKAY;
      rdata_q <= 32'h0;
    end else if (s_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_hit ? `PFM_RESP_OKAY : `PFM_RESP_SLVERR;
      rdata_q <= rd_hit ? rd_data : 32'h0;
    end else if (s_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : pfm_axil_slave
`default_nettype wire

// >>> verilog/pfm_pin_mux.sv
// Pin function select mux: remap and per-pin function registers steering pads
`timescale 1ns/10ps
`default_nettype none
`include "pfm_defs.svh"

module pfm_pin_mux #(
  parameter int ADDR_W = 8,
  parameter int NPINS = `PFM_NUM_PINS
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [NPINS-1:0] PAD_IN,
  output logic [NPINS-1:0] PAD_OUT,
  output logic [NPINS-1:0] PAD_OE,
  output logic [NPINS-1:0] PAD_ANALOG,
  input wire logic [NPINS-1:0] GPIO_OUT,
  input wire logic [NPINS-1:0] GPIO_OE,
  output logic [NPINS-1:0] GPIO_IN,
  input wire pfm_pkg::pfm_periph_out_t PERIPH_OUT,
  output pfm_pkg::pfm_periph_in_t PERIPH_IN
);

  logic [7:0] regs_q [`PFM_NUM_REGS];
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [NPINS-1:0] pad_meta_q;
  logic [NPINS-1:0] pad_sync_q;
  logic [NPINS-1:0] out_d;
  logic [NPINS-1:0] oe_d;
  logic [NPINS-1:0] ana_d;
  logic [NPINS-1:0] out_q;
  logic [NPINS-1:0] oe_q;
  logic [NPINS-1:0] ana_q;
  pfm_pkg::pfm_periph_in_t pin_d;
  pfm_pkg::pfm_periph_in_t pin_q;
  logic [7:0] remap;
  logic irq1_remap;
  logic rx_remap;
  logic tx_remap;
  logic sda_remap;
  logic scl_remap;
  pfm_pkg::pfm_cmp1_loc_t cmp1_loc;
  logic [1:0] pa0_c, pa1_c, pa2_c, pa3_c, pa4_c, pa5_c, pa6_c, pa7_c;
  logic [2:0] pb2_c;
  logic [1:0] pb0_c, pb1_c, pb3_c, pb4_c, pb5_c, pb6_c, pb7_c;
  logic [1:0] pd0_c, pd1_c, pd2_c, pd3_c;

  function automatic logic [7:0] reg_mask(input int idx);
    case (idx)
      0: reg_mask = `PFM_MASK_REMAP;
      3: reg_mask = `PFM_MASK_PB_LOW;
      5: reg_mask = `PFM_MASK_PB_TOP;
      7: reg_mask = `PFM_MASK_PC_HIGH;
      default: reg_mask = `PFM_MASK_FULL;
    endcase
  endfunction : reg_mask

  pfm_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_slave (
    .clk(CLK_SYS),
    .rst(RST),
    .s_awaddr(S_AXI_AWADDR),
    .s_awvalid(S_AXI_AWVALID),
    .s_awready(S_AXI_AWREADY),
    .s_wdata(S_AXI_WDATA),
    .s_wstrb(S_AXI_WSTRB),
    .s_wvalid(S_AXI_WVALID),
    .s_wready(S_AXI_WREADY),
    .s_bresp(S_AXI_BRESP),
    .s_bvalid(S_AXI_BVALID),
    .s_bready(S_AXI_BREADY),
    .s_araddr(S_AXI_ARADDR),
    .s_arvalid(S_AXI_ARVALID),
    .s_arready(S_AXI_ARREADY),
    .s_rdata(S_AXI_RDATA),
    .s_rresp(S_AXI_RRESP),
    .s_rvalid(S_AXI_RVALID),
    .s_rready(S_AXI_RREADY),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // Word index; any address beyond the last register answers SLVERR
  assign wr_idx = wr_addr[5:2];
  assign rd_idx = rd_addr[5:2];
  assign wr_hit = (wr_addr[1:0] == 2'b00) && (wr_addr[ADDR_W-1:6] == '0)
                  && (wr_idx < 4'(`PFM_NUM_REGS));
  assign rd_hit = (rd_addr[1:0] == 2'b00) && (rd_addr[ADDR_W-1:6] == '0)
                  && (rd_idx < 4'(`PFM_NUM_REGS));
  assign rd_data = rd_hit ? {24'h0, regs_q[rd_idx]} : 32'h0;

  // Only byte lane 0 carries a select register
  for (genvar gi = 0; gi < `PFM_NUM_REGS; gi++) begin : g_regs
    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        regs_q[gi] <= `PFM_RST_SEL;
      end else if (wr_en && wr_hit && wr_strb[0] && (wr_idx == 4'(gi))) begin
        regs_q[gi] <= wr_data[7:0] & reg_mask(gi);
      end
    end
  end

  // Two-flop synchroniser on every pad before any mux logic looks at it
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pad_meta_q <= '0;
      pad_sync_q <= '0;
    end else begin
      pad_meta_q <= PAD_IN;
      pad_sync_q <= pad_meta_q;
    end
  end

  assign remap = regs_q[0];
  assign irq1_remap = remap[`PFM_BIT_IRQ1_LOC];
  assign rx_remap = remap[`PFM_BIT_RX_LOC];
  assign tx_remap = remap[`PFM_BIT_TX_LOC];
  assign sda_remap = remap[`PFM_BIT_SDA_LOC];
  assign scl_remap = remap[`PFM_BIT_SCL_LOC];
  assign cmp1_loc = pfm_pkg::pfm_cmp1_loc_t'(remap[`PFM_BIT_CMP1_HI:`PFM_BIT_CMP1_LO]);

  // Effective codes: a remapped option whose remap is off falls back to 00
  assign pa0_c = (regs_q[1][1:0] == 2'b10 && !rx_remap) ? 2'b00 : regs_q[1][1:0];
  assign pa1_c = regs_q[1][3:2];
  assign pa2_c = (regs_q[1][5:4] == 2'b10 && !tx_remap) ? 2'b00 : regs_q[1][5:4];
  assign pa3_c = regs_q[1][7:6];
  assign pa4_c = (regs_q[2][1:0] == 2'b11 && cmp1_loc != pfm_pkg::PFM_CMP1_PA4) ? 2'b00
                 : regs_q[2][1:0];
  assign pa5_c = regs_q[2][3:2];
  assign pa6_c = (regs_q[2][5:4] == 2'b01 && cmp1_loc != pfm_pkg::PFM_CMP1_PA6) ? 2'b00
                 : regs_q[2][5:4];
  assign pa7_c = regs_q[2][7:6];
  assign pb0_c = regs_q[3][1:0];
  assign pb1_c = (regs_q[3][3:2] == 2'b11 && !scl_remap) ? 2'b00 : regs_q[3][3:2];
  assign pb2_c = (regs_q[3][6:4] == 3'b100 && !sda_remap) ? 3'b000 : regs_q[3][6:4];
  // Reserved location 11 leaves cmp1 negative on its home pin
  assign pb3_c = (regs_q[4][1:0] == 2'b01 && (cmp1_loc == pfm_pkg::PFM_CMP1_PA6
                 || cmp1_loc == pfm_pkg::PFM_CMP1_PA4)) ? 2'b00 : regs_q[4][1:0];
  assign pb4_c = regs_q[4][3:2];
  assign pb5_c = regs_q[4][5:4];
  assign pb6_c = (regs_q[4][7:6] == 2'b01 && rx_remap) ? 2'b00 : regs_q[4][7:6];
  assign pb7_c = (regs_q[5][1:0] == 2'b01 && tx_remap) ? 2'b00 : regs_q[5][1:0];
  assign pd0_c = regs_q[8][1:0];
  assign pd1_c = regs_q[8][3:2];
  assign pd2_c = regs_q[8][5:4];
  assign pd3_c = regs_q[8][7:6];

  always_comb begin
    out_d = GPIO_OUT;
    oe_d = GPIO_OE;
    ana_d = '0;
    // Port A
    if (pa0_c == 2'b01) begin
      out_d[`PFM_PA0] = 1'b0;
      oe_d[`PFM_PA0] = PERIPH_OUT.sda_drive_low;
    end else if (pa0_c == 2'b10) begin
      oe_d[`PFM_PA0] = 1'b0;
    end
    if (pa1_c == 2'b01) begin
      oe_d[`PFM_PA0+1] = 1'b0;
      ana_d[`PFM_PA0+1] = 1'b1;
    end
    if (pa2_c == 2'b01) begin
      out_d[`PFM_PA0+2] = 1'b0;
      oe_d[`PFM_PA0+2] = PERIPH_OUT.scl_drive_low;
    end else if (pa2_c == 2'b10) begin
      out_d[`PFM_PA0+2] = PERIPH_OUT.uart_tx;
      oe_d[`PFM_PA0+2] = 1'b1;
    end
    if (pa3_c == 2'b01) begin
      oe_d[`PFM_PA0+3] = 1'b0;
      ana_d[`PFM_PA0+3] = 1'b1;
    end
    if (pa4_c[1]) begin
      oe_d[`PFM_PA0+4] = 1'b0;
      ana_d[`PFM_PA0+4] = 1'b1;
    end
    if (pa5_c == 2'b10) begin
      oe_d[`PFM_PA0+5] = 1'b0;
      ana_d[`PFM_PA0+5] = 1'b1;
    end
    if (pa6_c == 2'b01 || pa6_c == 2'b10) begin
      oe_d[`PFM_PA0+6] = 1'b0;
      ana_d[`PFM_PA0+6] = 1'b1;
    end
    if (pa7_c == 2'b01) begin
      oe_d[`PFM_PA0+7] = 1'b0;
      ana_d[`PFM_PA0+7] = 1'b1;
    end
    // Port B
    unique case (pb0_c)
      2'b01: begin
        out_d[`PFM_PB0] = PERIPH_OUT.hall_out[0];
        oe_d[`PFM_PB0] = 1'b1;
      end
      2'b10: begin
        oe_d[`PFM_PB0] = 1'b0;
        ana_d[`PFM_PB0] = 1'b1;
      end
      2'b11: begin
        out_d[`PFM_PB0] = PERIPH_OUT.timer2_out[0];
        oe_d[`PFM_PB0] = 1'b1;
      end
      2'b00: begin
      end
    endcase
    unique case (pb1_c)
      2'b01: begin
        out_d[`PFM_PB0+1] = PERIPH_OUT.hall_out[1];
        oe_d[`PFM_PB0+1] = 1'b1;
      end
      2'b10: begin
        oe_d[`PFM_PB0+1] = 1'b0;
        ana_d[`PFM_PB0+1] = 1'b1;
      end
      2'b11: begin
        out_d[`PFM_PB0+1] = 1'b0;
        oe_d[`PFM_PB0+1] = PERIPH_OUT.scl_drive_low;
      end
      2'b00: begin
      end
    endcase
    if (pb2_c == 3'b001) begin
      out_d[`PFM_PB0+2] = PERIPH_OUT.hall_out[2];
      oe_d[`PFM_PB0+2] = 1'b1;
    end else if (pb2_c == 3'b010) begin
      oe_d[`PFM_PB0+2] = 1'b0;
      ana_d[`PFM_PB0+2] = 1'b1;
    end else if (pb2_c == 3'b011) begin
      out_d[`PFM_PB0+2] = PERIPH_OUT.timer2_out[1];
      oe_d[`PFM_PB0+2] = 1'b1;
    end else if (pb2_c == 3'b100) begin
      out_d[`PFM_PB0+2] = 1'b0;
      oe_d[`PFM_PB0+2] = PERIPH_OUT.sda_drive_low;
    end
    if (pb3_c == 2'b01) begin
      oe_d[`PFM_PB0+3] = 1'b0;
      ana_d[`PFM_PB0+3] = 1'b1;
    end
    if (pb4_c == 2'b01) begin
      out_d[`PFM_PB0+4] = PERIPH_OUT.timer3_out[0];
      oe_d[`PFM_PB0+4] = 1'b1;
    end
    if (pb5_c == 2'b01) begin
      out_d[`PFM_PB0+5] = PERIPH_OUT.timer3_out[1];
      oe_d[`PFM_PB0+5] = 1'b1;
    end
    if (pb6_c == 2'b01) begin
      oe_d[`PFM_PB0+6] = 1'b0;
    end else if (pb6_c == 2'b10) begin
      out_d[`PFM_PB0+6] = PERIPH_OUT.timer2_out[0];
      oe_d[`PFM_PB0+6] = 1'b1;
    end
    if (pb7_c == 2'b01) begin
      out_d[`PFM_PB0+7] = PERIPH_OUT.uart_tx;
      oe_d[`PFM_PB0+7] = 1'b1;
    end else if (pb7_c == 2'b10) begin
      out_d[`PFM_PB0+7] = PERIPH_OUT.timer2_out[1];
      oe_d[`PFM_PB0+7] = 1'b1;
    end
    // Port C gate drives
    for (int i = 0; i < 6; i++) begin
      if (regs_q[6 + i / 4][2*(i%4) +: 2] == 2'b10) begin
        out_d[`PFM_PC0+i] = PERIPH_OUT.gate_drive[i];
        oe_d[`PFM_PC0+i] = 1'b1;
      end
    end
    // Port D
    if (pd0_c == 2'b01) begin
      oe_d[`PFM_PD0] = 1'b0;
      ana_d[`PFM_PD0] = 1'b1;
    end else if (pd0_c == 2'b10) begin
      out_d[`PFM_PD0] = PERIPH_OUT.timer0_out[0];
      oe_d[`PFM_PD0] = 1'b1;
    end
    if (pd1_c == 2'b01) begin
      oe_d[`PFM_PD0+1] = 1'b0;
      ana_d[`PFM_PD0+1] = 1'b1;
    end else if (pd1_c == 2'b10) begin
      out_d[`PFM_PD0+1] = PERIPH_OUT.timer0_out[1];
      oe_d[`PFM_PD0+1] = 1'b1;
    end
    if (pd2_c == 2'b01) begin
      out_d[`PFM_PD0+2] = PERIPH_OUT.timer1_out[0];
      oe_d[`PFM_PD0+2] = 1'b1;
    end
    if (pd3_c == 2'b01) begin
      out_d[`PFM_PD0+3] = PERIPH_OUT.timer1_out[1];
      oe_d[`PFM_PD0+3] = 1'b1;
    end
  end

  // Inputs idle high for serial lines and low for the rest when unrouted
  always_comb begin
    pin_d.uart_rx = rx_remap ? (pa0_c == 2'b10 ? pad_sync_q[`PFM_PA0] : 1'b1)
                    : (pb6_c == 2'b01 ? pad_sync_q[`PFM_PB0+6] : 1'b1);
    pin_d.sda_in = sda_remap ? (pb2_c == 3'b100 ? pad_sync_q[`PFM_PB0+2] : 1'b1)
                   : (pa0_c == 2'b01 ? pad_sync_q[`PFM_PA0] : 1'b1);
    pin_d.scl_in = scl_remap ? (pb1_c == 2'b11 ? pad_sync_q[`PFM_PB0+1] : 1'b1)
                   : (pa2_c == 2'b01 ? pad_sync_q[`PFM_PA0+2] : 1'b1);
    pin_d.external_irq_1 = irq1_remap ? (pd2_c != 2'b01 && pad_sync_q[`PFM_PD0+2])
                           : (pb0_c == 2'b00 && pad_sync_q[`PFM_PB0]);
    pin_d.timer1_clock_input = (pa3_c != 2'b01) && pad_sync_q[`PFM_PA0+3];
    pin_d.timer2_clock_input = (pa1_c != 2'b01) && pad_sync_q[`PFM_PA0+1];
    pin_d.hall_in[0] = (pa3_c != 2'b01) && pad_sync_q[`PFM_PA0+3];
    pin_d.hall_in[1] = !pa4_c[1] && pad_sync_q[`PFM_PA0+4];
    pin_d.hall_in[2] = (pa5_c != 2'b10) && pad_sync_q[`PFM_PA0+5];
    pin_d.capture_timer_input = (pb1_c == 2'b00) && pad_sync_q[`PFM_PB0+1];
    pin_d.noise_filter_input = (pa7_c != 2'b01) && pad_sync_q[`PFM_PA0+7];
  end

  // Registered so pads and peripherals never see a decode glitch
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      out_q <= '0;
      oe_q <= '0;
      ana_q <= '0;
      pin_q <= '0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      ana_q <= ana_d;
      pin_q <= pin_d;
    end
  end

  assign PAD_OUT = out_q;
  assign PAD_OE = oe_q;
  assign PAD_ANALOG = ana_q;
  assign PERIPH_IN = pin_q;
  assign GPIO_IN = pad_sync_q;

  a_irq1_route: assert property (@(posedge CLK_SYS) disable iff (RST)
    (irq1_remap && pd2_c != 2'b01) |=> PERIPH_IN.external_irq_1 == $past(pad_sync_q[`PFM_PD0+2]))
    else $error("irq1 not taken from PD2 when remapped");
  a_rx_route: assert property (@(posedge CLK_SYS) disable iff (RST)
    (!rx_remap && regs_q[4][7:6] != 2'b01) |=> PERIPH_IN.uart_rx)
    else $error("receive input not idle while unrouted");
  a_tx_place: assert property (@(posedge CLK_SYS) disable iff (RST)
    (tx_remap && regs_q[1][5:4] == 2'b10) |=> (PAD_OE[2] && PAD_OUT[2] == $past(PERIPH_OUT.uart_tx)))
    else $error("transmit not driven on PA2");
  a_cmp1_loc: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cmp1_loc == pfm_pkg::PFM_CMP1_RSVD && regs_q[2][5:4] == 2'b01) |=> !PAD_ANALOG[6])
    else $error("reserved cmp1 location selected PA6");
  a_i2c_clock: assert property (@(posedge CLK_SYS) disable iff (RST)
    (scl_remap && regs_q[3][3:2] == 2'b11) |=> (PAD_OUT[9] == 1'b0
      && PAD_OE[9] == $past(PERIPH_OUT.scl_drive_low)))
    else $error("SCL not open drain on PB1");
  a_unused_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
    (regs_q[0][7] == 1'b0 && regs_q[3][7] == 1'b0 && regs_q[5][7:2] == 6'h00
      && regs_q[7][7:4] == 4'h0))
    else $error("unimplemented select bit set");
  a_remap_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
    (!sda_remap && regs_q[3][6:4] == 3'b100) |=> PAD_OE[10] == $past(GPIO_OE[10]))
    else $error("unenabled remap code did not act as default");
  a_gate_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
    (regs_q[6][1:0] == 2'b10) |=> (PAD_OE[16] && PAD_OUT[16] == $past(PERIPH_OUT.gate_drive[0])))
    else $error("gate drive missing on PC0");
  a_reset_clear: assert property (@(posedge CLK_SYS)
    RST |=> (remap == 8'h00 && regs_q[8] == 8'h00 && PAD_ANALOG == '0))
    else $error("select registers not cleared by reset");

  c_tx_remapped: cover property (@(posedge CLK_SYS) disable iff (RST)
    tx_remap && regs_q[1][5:4] == 2'b10);
  c_cmp1_pa4: cover property (@(posedge CLK_SYS) disable iff (RST)
    cmp1_loc == pfm_pkg::PFM_CMP1_PA4 && regs_q[2][1:0] == 2'b11);
  c_gate_all: cover property (@(posedge CLK_SYS) disable iff (RST)
    regs_q[6] == 8'haa && regs_q[7] == 8'h0a);

endmodule : pfm_pin_mux
`default_nettype wire

// >>> tb/pfm_periph_model.sv
// Stand-in for the peripherals and port logic behind the pin function mux
`timescale 1ns/10ps
`default_nettype none

module pfm_periph_model (
  input wire logic flip,
  output var pfm_pkg::pfm_periph_out_t periph_out,
  output var logic [25:0] gpio_out,
  output var logic [25:0] gpio_oe
);
  // Every source inverts with flip, so a stuck pad cannot pass for a routed one
  assign periph_out = flip ? ~20'ha5c3a : 20'ha5c3a;
  assign gpio_out = flip ? ~26'h2a5c3a6 : 26'h2a5c3a6;
  assign gpio_oe = flip ? ~26'h1c3a5c9 : 26'h1c3a5c9;
endmodule : pfm_periph_model

`default_nettype wire

// >>> tb/pin_function_select_mux_test.sv
// Testbench for the pin function mux: register access and pad steering
`timescale 1ns/10ps
`default_nettype none
`include "pfm_defs.svh"

module pin_function_select_mux_test;
  logic clk, rst, flip;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [25:0] pad_in, pad_out, pad_oe, gpio_out, gpio_oe, ana, gin;
  pfm_pkg::pfm_periph_out_t per;
  pfm_pkg::pfm_periph_in_t pin;
  int errors, tests_run;
  logic [7:0] masks [9] = '{8'h7f, 8'hff, 8'hff, 8'h7f, 8'hff, 8'h03, 8'hff, 8'h0f, 8'hff};

  pfm_pin_mux dut (.CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_ANALOG(ana), .GPIO_OUT(gpio_out),
    .GPIO_OE(gpio_oe), .GPIO_IN(gin), .PERIPH_OUT(per), .PERIPH_IN(pin));

  pfm_periph_model model (.flip(flip), .periph_out(per), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task wrap_up;
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask : rd

  // Source k: 0 transmit, 1 timer2 out0, 2 timer3 out0, 3 gate drive, 4 timer1 out0,
  // 6 analog, 7 SDA open drain, 8 SCL open drain, else GPIO
  task steer(input logic [7:0] a, input logic [7:0] v, input int p, input int k);
    logic [1:0] e;
    wr(a, {24'h0, v});
    for (int f = 0; f < 2; f++) begin
      flip <= f[0];
      repeat (3) @(posedge clk);
      case (k)
        0: e = {1'b1, per.uart_tx};
        1: e = {1'b1, per.timer2_out[0]};
        2: e = {1'b1, per.timer3_out[0]};
        3: e = {1'b1, per.gate_drive[p-16]};
        4: e = {1'b1, per.timer1_out[0]};
        6: e = 2'b01;
        7: e = {per.sda_drive_low, 1'b0};
        8: e = {per.scl_drive_low, 1'b0};
        default: e = {gpio_oe[p], gpio_out[p]};
      endcase
      // Analog pins: drive off and analog flag set; all others: analog flag clear
      if (k == 6) cmp({30'h0, pad_oe[p], ana[p]}, {30'h0, e});
      else cmp({29'h0, ana[p], pad_oe[p], pad_out[p]}, {30'h0, e});
    end
  endtask : steer

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    wrap_up();
  end

  initial begin
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    flip = 1'b0;
    {awaddr, araddr, wdata, pad_in} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    cmp({6'h0, pad_oe}, {6'h0, gpio_oe});
    for (int i = 0; i < 9; i++) begin
      rd(8'(i * 4));
      cmp(d, 32'h0);
      wr(8'(i * 4), 32'hffffffff);
      rd(8'(i * 4));
      cmp(d, {24'h0, masks[i]});
      wr(8'(i * 4), 32'h0);
    end
    wr(8'h24, 32'h5);
    cmp({30'h0, r}, {30'h0, `PFM_RESP_SLVERR});
    steer(`PFM_OFS_PA_LOW, 8'h20, 2, 5);
    wr(`PFM_OFS_REMAP, 32'h10);
    steer(`PFM_OFS_PA_LOW, 8'h20, 2, 0);
    steer(`PFM_OFS_PB_LOW, 8'h03, 8, 1);
    steer(`PFM_OFS_PB_MID, 8'h80, 14, 1);
    steer(`PFM_OFS_PB_MID, 8'h04, 12, 2);
    steer(`PFM_OFS_PC_LOW, 8'h20, 18, 3);
    steer(`PFM_OFS_PD, 8'h10, 24, 4);
    steer(`PFM_OFS_PB_TOP, 8'h01, 15, 5);
    steer(`PFM_OFS_PA_LOW, 8'h04, 1, 6);
    steer(`PFM_OFS_PA_LOW, 8'h01, 0, 7);
    steer(`PFM_OFS_PA_HIGH, 8'h20, 6, 6);
    steer(`PFM_OFS_PB_LOW, 8'h20, 10, 6);
    steer(`PFM_OFS_PD, 8'h04, 23, 6);
    wr(`PFM_OFS_REMAP, 32'h09);
    steer(`PFM_OFS_PA_HIGH, 8'h03, 4, 6);
    steer(`PFM_OFS_PB_MID, 8'h01, 11, 5);
    steer(`PFM_OFS_PB_LOW, 8'h0c, 9, 8);
    wr(`PFM_OFS_PD, 32'h0);
    wr(`PFM_OFS_REMAP, 32'h60);
    wr(`PFM_OFS_PA_LOW, 32'h02);
    // Old receive and irq pins carry the opposite level to catch a missed move
    for (int b = 0; b < 2; b++) begin
      pad_in <= b[0] ? 26'h1000001 : 26'h0004100;
      repeat (5) @(posedge clk);
      cmp({30'h0, pin.uart_rx, pin.external_irq_1}, {30'h0, b[0], b[0]});
      cmp({6'h0, gin}, {6'h0, pad_in});
    end
    // Reset in mid-run must clear selects that were left non-zero
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`PFM_OFS_REMAP);
    cmp(d, 32'h0);
    cmp({6'h0, ana}, 32'h0);
    wrap_up();
  end
endmodule : pin_function_select_mux_test

`default_nettype wire
